// file: include/ddc_defines.vh
/*
 * register offsets, field positions and reset values for the
 * dds phase and pattern configuration bank.
 * assumes a 16-bit register address and 16-bit register data.
 */
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH

// register offsets (register address space)
`define DDC_ADDR_TW_HIGH      16'h003E
`define DDC_ADDR_TW_LOW       16'h003F
`define DDC_ADDR_PHASE_CH4    16'h0040
`define DDC_ADDR_PHASE_CH3    16'h0041
`define DDC_ADDR_PHASE_CH2    16'h0042
`define DDC_ADDR_PHASE_CH1    16'h0043
`define DDC_ADDR_PAT_CTRL1    16'h0044
`define DDC_ADDR_PAT_CTRL2    16'h0045

// reset values
`define DDC_RST_WORD          16'h0000

// tuning word low register: low byte of tuning word in [15:8]
`define DDC_TWL_MSB           15
`define DDC_TWL_LSB           8

// pattern control one
`define DDC_BIT_FIRST_ONLY    1

// pattern control two
`define DDC_BIT_COS_CH4       15
`define DDC_BIT_MSBCLK_CH4    14
`define DDC_BIT_COS_CH3       11
`define DDC_BIT_MSBCLK_CH3    10
`define DDC_BIT_PHMEM_CH3     9

// memory phase: upper 8 of 12 data bits feed the phase msbs
`define DDC_MEM_PH_MSB        11
`define DDC_MEM_PH_LSB        4
`define DDC_MEM_PH_FILL       8'h00

`endif

// file: hw/ddc_dds_config.v
/*
 * dds phase and pattern configuration register bank: tuning word,
 * four phase offsets, trigger delay mode, cosine / address clock
 * selects for channels 4 and 3, memory phase select for channel 3, and the small amount
 * of logic those bits steer; each register word is one instance of
 * a small reset-and-write cell kept at the end of this file.
 * assumes: the serial port engine presents decoded single-cycle
 * register writes and reads on core_clk_i (the dac sample clock);
 * dds msb, pattern boundary and memory data come from logic on the
 * same clock, so none of them is synchronised here.
 */
// Overview of operation
// RULE1: tuning low byte in [15:8], [7:0] stored, reset zero
// RULE2: upper sixteen tuning bits joined with low byte
// RULE3: sixteen-bit phase maps linearly onto full cycle
// RULE4: phase offsets reset to zero phase shift
// RULE5: one bit picks repeating or first-only start delay
// RULE6: cosine select per channel 4 and 3
// RULE7: address advance every clock or on msb rise
// RULE8: software uses msb advance for tuning word lists
// RULE9: bit 9 takes channel 3 phase from memory
// RULE10: memory phase bits on top, zeros below
`timescale 1ns/1ns
`include "ddc_defines.vh"

module ddc_dds_config #(
   parameter TW_WIDTH    = 24,
   parameter PH_WIDTH    = 16,
   parameter MEM_WIDTH   = 12
) (
   input  wire                 core_clk_i,
   input  wire                 rst_i,
   // register port
   input  wire [15:0]          reg_addr_i,
   input  wire [15:0]          reg_wdata_i,
   input  wire                 reg_wr_i,
   input  wire                 reg_rd_i,
   output reg  [15:0]          reg_rdata_o,
   output reg                  reg_rvalid_o,
   // dds datapath controls
   output wire [TW_WIDTH-1:0]  tuning_word_o,
   output wire [PH_WIDTH-1:0]  phase_offset_value_ch4_o,
   output wire [PH_WIDTH-1:0]  phase_offset_value_ch3_o,
   output wire [PH_WIDTH-1:0]  phase_offset_value_ch2_o,
   output wire [PH_WIDTH-1:0]  phase_offset_value_ch1_o,
   output wire                 cosine_select_ch4_o,
   output wire                 cosine_select_ch3_o,
   output wire                 addr_clock_from_msb_ch4_o,
   output wire                 addr_clock_from_msb_ch3_o,
   output wire                 phase_from_memory_ch3_o,
   output wire                 first_pattern_only_delay_o,
   // pattern memory address advance
   input  wire                 dds_msb_ch4_i,
   input  wire                 dds_msb_ch3_i,
   output wire                 addr_advance_ch4_o,
   output wire                 addr_advance_ch3_o,
   // channel 3 phase word read at its start address
   input  wire [MEM_WIDTH-1:0] mem_data_ch3_i,
   // start delay gating
   input  wire                 run_start_i,
   input  wire                 pattern_boundary_i,
   output wire                 apply_start_delay_o
);

   wire [15:0] tw_high_reg;
   wire [15:0] tw_low_reg;
   wire [15:0] phase_ch4_reg;
   wire [15:0] phase_ch3_reg;
   wire [15:0] phase_ch2_reg;
   wire [15:0] phase_ch1_reg;
   wire [15:0] pat_ctrl1_reg;
   wire [15:0] pat_ctrl2_reg;
   reg  [15:0] rdata_next;
   reg         msb_ch4_d_reg;
   reg         msb_ch3_d_reg;
   reg         first_done_reg;
   reg  [15:0] ph3_reg_src;
   reg  [15:0] ph3_mem_src;

   // one cell per register word; reserved bits are stored and read
   // back as written, so software can round-trip any value
   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_TW_HIGH),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_tw_high_inst (                     // [RULE2]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (tw_high_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_TW_LOW),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_tw_low_inst (                      // [RULE1]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (tw_low_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PHASE_CH4),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_phase_ch4_inst (                   // [RULE4]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (phase_ch4_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PHASE_CH3),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_phase_ch3_inst (                   // [RULE4]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (phase_ch3_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PHASE_CH2),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_phase_ch2_inst (                   // [RULE4]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (phase_ch2_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PHASE_CH1),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_phase_ch1_inst (                   // [RULE4]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (phase_ch1_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PAT_CTRL1),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_pat_ctrl1_inst (                   // [RULE5]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (pat_ctrl1_reg)
   );

   ddc_cfg_reg #(
      .WIDTH     (16),
      .ADDR      (`DDC_ADDR_PAT_CTRL2),
      .RESET_VAL (`DDC_RST_WORD)
   ) ddc_cfg_reg_pat_ctrl2_inst (           // [RULE6] [RULE7] [RULE9]
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .value_o     (pat_ctrl2_reg)
   );

   // read mux; unmapped addresses read as zero
   always @* begin
      rdata_next = 16'h0000;
      if (reg_addr_i == `DDC_ADDR_TW_HIGH) begin
         rdata_next = tw_high_reg;
      end else if (reg_addr_i == `DDC_ADDR_TW_LOW) begin
         rdata_next = tw_low_reg;
      end else if (reg_addr_i == `DDC_ADDR_PHASE_CH4) begin
         rdata_next = phase_ch4_reg;
      end else if (reg_addr_i == `DDC_ADDR_PHASE_CH3) begin
         rdata_next = phase_ch3_reg;
      end else if (reg_addr_i == `DDC_ADDR_PHASE_CH2) begin
         rdata_next = phase_ch2_reg;
      end else if (reg_addr_i == `DDC_ADDR_PHASE_CH1) begin
         rdata_next = phase_ch1_reg;
      end else if (reg_addr_i == `DDC_ADDR_PAT_CTRL1) begin
         rdata_next = pat_ctrl1_reg;
      end else if (reg_addr_i == `DDC_ADDR_PAT_CTRL2) begin
         rdata_next = pat_ctrl2_reg;
      end
   end

   // read data held until the next read so the port engine can shift it
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         reg_rdata_o  <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
         end
      end
   end

   // full tuning word: high half on top, low byte from [15:8]
   assign tuning_word_o = {tw_high_reg,
                           tw_low_reg[`DDC_TWL_MSB:`DDC_TWL_LSB]}; // [RULE2]

   // control bit fan-out
   assign first_pattern_only_delay_o =
      pat_ctrl1_reg[`DDC_BIT_FIRST_ONLY];                         // [RULE5]
   assign cosine_select_ch4_o = pat_ctrl2_reg[`DDC_BIT_COS_CH4];  // [RULE6]
   assign cosine_select_ch3_o = pat_ctrl2_reg[`DDC_BIT_COS_CH3];  // [RULE6]
   assign addr_clock_from_msb_ch4_o =
      pat_ctrl2_reg[`DDC_BIT_MSBCLK_CH4];                         // [RULE7]
   assign addr_clock_from_msb_ch3_o =
      pat_ctrl2_reg[`DDC_BIT_MSBCLK_CH3];                         // [RULE7]
   assign phase_from_memory_ch3_o =
      pat_ctrl2_reg[`DDC_BIT_PHMEM_CH3];                          // [RULE9]

   // phase words pass straight through: the full 16-bit range is
   // one cycle, so 0x4000 is a quarter turn with no scaling needed
   assign phase_offset_value_ch4_o = phase_ch4_reg;               // [RULE3]
   assign phase_offset_value_ch2_o = phase_ch2_reg;               // [RULE3]
   assign phase_offset_value_ch1_o = phase_ch1_reg;               // [RULE3]

   // channel 3 phase source: register, or top 8 memory bits
   always @* begin
      ph3_reg_src = phase_ch3_reg;
      ph3_mem_src = {mem_data_ch3_i[`DDC_MEM_PH_MSB:`DDC_MEM_PH_LSB],
                     `DDC_MEM_PH_FILL};                           // [RULE10]
   end
   assign phase_offset_value_ch3_o = phase_from_memory_ch3_o ?
                                     ph3_mem_src : ph3_reg_src;   // [RULE9]

   // msb history for rising-edge detection of the dds output msb
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         msb_ch4_d_reg <= 1'b0;
         msb_ch3_d_reg <= 1'b0;
      end else begin
         msb_ch4_d_reg <= dds_msb_ch4_i;
         msb_ch3_d_reg <= dds_msb_ch3_i;
      end
   end

   // one advance per dds output cycle lets a memory of tuning words
   // step once per generated period instead of once per sample
   assign addr_advance_ch4_o = ~addr_clock_from_msb_ch4_o |
                               (dds_msb_ch4_i & ~msb_ch4_d_reg);  // [RULE7]
   assign addr_advance_ch3_o = ~addr_clock_from_msb_ch3_o |
                               (dds_msb_ch3_i & ~msb_ch3_d_reg);  // [RULE7]

   // remembers that the first pattern of a run has begun; a boundary
   // in the same cycle as a run start is that run's first pattern,
   // so the set wins over the re-arm
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         first_done_reg <= 1'b0;
      end else if (pattern_boundary_i) begin
         first_done_reg <= 1'b1;                                 // [RULE5]
      end else if (run_start_i) begin
         first_done_reg <= 1'b0;
      end
   end

   // delay before every pattern, or only before the first one
   assign apply_start_delay_o = pattern_boundary_i &
                                (~first_pattern_only_delay_o |
                                 ~first_done_reg | run_start_i); // [RULE5]

endmodule

// one configuration word: synchronous reset to its documented value
// and a full-word write when the decoded address matches; a cell per
// word keeps the address compare next to the storage it guards
module ddc_cfg_reg #(
   parameter                   WIDTH     = 16,
   parameter [15:0]            ADDR      = 16'h0000,
   parameter [WIDTH-1:0]       RESET_VAL = 16'h0000
) (
   input  wire                 core_clk_i,
   input  wire                 rst_i,
   input  wire [15:0]          reg_addr_i,
   input  wire [WIDTH-1:0]     reg_wdata_i,
   input  wire                 reg_wr_i,
   output reg  [WIDTH-1:0]     value_o
);

   // the write strobe is a one-cycle pulse, so no edge logic is needed
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         value_o <= RESET_VAL;
      end else if (reg_wr_i && (reg_addr_i == ADDR)) begin
         value_o <= reg_wdata_i;
      end
   end

endmodule

// file: verification/ddc_dds_config_asserts.sv
/* assertion checker for the dds configuration bank.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`include "ddc_defines.vh"
module ddc_dds_config_asserts (
   input wire        core_clk_i,
   input wire        rst_i,
   input wire [15:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire [23:0] tuning_word_o,
   input wire [15:0] phase_offset_value_ch4_o,
   input wire [15:0] phase_offset_value_ch3_o,
   input wire        cosine_select_ch4_o,
   input wire        addr_clock_from_msb_ch3_o,
   input wire        addr_advance_ch3_o,
   input wire        phase_from_memory_ch3_o,
   input wire [11:0] mem_data_ch3_i,
   input wire        first_pattern_only_delay_o,
   input wire        run_start_i,
   input wire        pattern_boundary_i,
   input wire        apply_start_delay_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // register writes land on the edge after the strobe
   a_tw_low_byte: assert property (
      reg_wr_i && reg_addr_i == `DDC_ADDR_TW_LOW |=>
      tuning_word_o[7:0] == $past(reg_wdata_i[15:8])) else $error("tw low");
   a_tw_high_half: assert property (
      reg_wr_i && reg_addr_i == `DDC_ADDR_TW_HIGH |=>
      tuning_word_o[23:8] == $past(reg_wdata_i)) else $error("tw high");
   a_phase_write: assert property (
      reg_wr_i && reg_addr_i == `DDC_ADDR_PHASE_CH4 |=>
      phase_offset_value_ch4_o == $past(reg_wdata_i)) else $error("phase");
   a_phase_reset: assert property (
      $past(rst_i) |-> phase_offset_value_ch4_o == 16'h0000)
      else $error("phase not zero after reset");
   a_delay_repeats: assert property (
      !first_pattern_only_delay_o && pattern_boundary_i |->
      apply_start_delay_o) else $error("delay missing");
   a_delay_first_only: assert property (
      first_pattern_only_delay_o && pattern_boundary_i && !run_start_i &&
      $past(pattern_boundary_i) && !$past(rst_i) |->
      !apply_start_delay_o) else $error("delay repeated");
   a_cos_write: assert property (
      reg_wr_i && reg_addr_i == `DDC_ADDR_PAT_CTRL2 |=>
      cosine_select_ch4_o == $past(reg_wdata_i[15])) else $error("cos");
   a_adv_dac_clk: assert property (
      !addr_clock_from_msb_ch3_o |-> addr_advance_ch3_o)
      else $error("advance missing");
   a_mem_phase: assert property (
      phase_from_memory_ch3_o |-> phase_offset_value_ch3_o ==
      {mem_data_ch3_i[11:4], 8'h00}) else $error("memory phase");
endmodule
bind ddc_dds_config ddc_dds_config_asserts ddc_dds_config_asserts_inst (
   .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .tuning_word_o, .phase_offset_value_ch4_o, .phase_offset_value_ch3_o,
   .cosine_select_ch4_o, .addr_clock_from_msb_ch3_o, .addr_advance_ch3_o,
   .phase_from_memory_ch3_o, .mem_data_ch3_i, .first_pattern_only_delay_o,
   .pattern_boundary_i, .apply_start_delay_o, .run_start_i);

// file: verification/tb_top.sv
/* self-checking bench for the dds configuration bank.
   assumes the bank answers reads one cycle after the strobe. */
`timescale 1ns/1ns
`include "ddc_defines.vh"
module tb_top;
   logic core_clk_i = 1'h0, rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic dds_msb_ch4_i = 1'h0, dds_msb_ch3_i = 1'h0, run_start_i = 1'h0;
   logic pattern_boundary_i = 1'h0, reg_rvalid_o, apply_start_delay_o;
   logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o;
   logic [11:0] mem_data_ch3_i = 12'h000;
   logic [23:0] tuning_word_o;
   logic [15:0] phase_offset_value_ch4_o, phase_offset_value_ch3_o;
   logic [15:0] phase_offset_value_ch2_o, phase_offset_value_ch1_o;
   logic cosine_select_ch4_o, cosine_select_ch3_o, phase_from_memory_ch3_o;
   logic addr_clock_from_msb_ch4_o, addr_clock_from_msb_ch3_o;
   logic addr_advance_ch4_o, addr_advance_ch3_o, first_pattern_only_delay_o;
   int err_total = 0, checks = 0;
   ddc_dds_config ddc_dds_config_inst (.*);
   // 100 MHz clock
   always #5 core_clk_i = ~core_clk_i;
   task chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobes are held one cycle and dropped on the taking edge
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'h1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'h0;
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'h1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'h0;
      #1 chk({reg_rvalid_o, reg_rdata_o}, {8'h01, e});
   endtask
   // all banked registers and one unmapped slot read zero
   task t_reset;
      for (int a = 16'h3E; a <= 16'h46; a++) rd(a[15:0], 16'h0000);
   endtask
   task t_tuning;
      wr(`DDC_ADDR_TW_HIGH, 16'h1234);
      wr(`DDC_ADDR_TW_LOW, 16'h56AB);
      #1 chk(tuning_word_o, 24'h123456);
      rd(`DDC_ADDR_TW_LOW, 16'h56AB);
      wr(16'h0046, 16'hFFFF);
      rd(16'h0046, 16'h0000);
   endtask
   task t_phase;
      wr(`DDC_ADDR_PHASE_CH4, 16'h4000);
      wr(`DDC_ADDR_PHASE_CH3, 16'h8000);
      wr(`DDC_ADDR_PHASE_CH2, 16'hC000);
      #1 chk({phase_offset_value_ch4_o, 8'h00}, 24'h400000);
      chk(phase_offset_value_ch2_o, 24'h00C000);
      chk(phase_offset_value_ch1_o, 24'h000000);
      rd(`DDC_ADDR_PHASE_CH3, 16'h8000);
      wr(`DDC_ADDR_PHASE_CH1, 16'h4000);
      #1 chk(phase_offset_value_ch1_o, 24'h004000);
   endtask
   // msb-driven advance pulses only on the msb rise
   task t_ctrl;
      wr(`DDC_ADDR_PAT_CTRL2, 16'h8E00);
      mem_data_ch3_i <= 12'hABC;
      #1 chk({cosine_select_ch4_o, cosine_select_ch3_o}, 24'h3);
      chk({addr_clock_from_msb_ch4_o, addr_clock_from_msb_ch3_o,
           phase_from_memory_ch3_o}, 24'h3);
      @(posedge core_clk_i);
      dds_msb_ch3_i <= 1'h1;
      #1 chk(phase_offset_value_ch3_o, 24'h00AB00);
      chk({addr_advance_ch4_o, addr_advance_ch3_o}, 24'h3);
      @(posedge core_clk_i);
      #1 chk({addr_advance_ch4_o, addr_advance_ch3_o}, 24'h2);
      wr(`DDC_ADDR_PAT_CTRL2, 16'h4000);
      #1 chk(phase_offset_value_ch3_o, 24'h008000);
      chk({addr_advance_ch4_o, addr_advance_ch3_o}, 24'h1);
      @(posedge core_clk_i);
      dds_msb_ch4_i <= 1'h1;
      #1 chk({addr_advance_ch4_o, addr_advance_ch3_o}, 24'h3);
      rd(`DDC_ADDR_PAT_CTRL2, 16'h4000);
   endtask
   task t_delay;
      repeat (2) begin
         @(posedge core_clk_i);
         pattern_boundary_i <= 1'h1;
         #1 chk(apply_start_delay_o, 24'h1);
      end
      @(posedge core_clk_i);
      pattern_boundary_i <= 1'h0;
      wr(`DDC_ADDR_PAT_CTRL1, 16'h0002);
      run_start_i <= 1'h1;
      @(posedge core_clk_i);
      run_start_i <= 1'h0;
      pattern_boundary_i <= 1'h1;
      #1 chk(apply_start_delay_o, 24'h1);
      chk(first_pattern_only_delay_o, 24'h1);
      @(posedge core_clk_i);
      #1 chk(apply_start_delay_o, 24'h0);
      // a run start on a boundary counts as that run's first pattern
      @(posedge core_clk_i);
      run_start_i <= 1'h1;
      #1 chk(apply_start_delay_o, 24'h1);
      @(posedge core_clk_i);
      run_start_i <= 1'h0;
      #1 chk(apply_start_delay_o, 24'h0);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   initial begin
      #20000;
      err_total++;
      summarize;
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'h0;
      t_reset;
      t_tuning;
      t_phase;
      t_ctrl;
      t_delay;
      summarize;
   end
endmodule
